/* src/esp_cfg.svh */
/*
 Register map, field positions, mode codes and timing counts for the
 enhanced serial port. Assumes inclusion by every module file of the
 block; holds definitions only.

 // What this block does
 // RL1 - Four modes: synchronous 8-bit, async 8-bit, async 9-bit fixed, async 9-bit timer.
 // RL2 - Completion sets tx_done_flag or rx_done_flag; only software clears them.
 // RL3 - One data buffer address: write loads transmitter, read returns received byte.
 // RL4 - Received byte held so next reception proceeds; overrun flagged on unread overwrite.
 // RL5 - Mode 0: device is master, clock on tx pin, data half-duplex on rx pin.
 // RL6 - Mode 0: buffer write sends eight bits LSB first; done after eighth bit.
 // RL7 - Mode 0: receive when enabled and rx flag clear; flag one cycle after bit eight.
 // RL8 - Mode 0: shift rate is system clock over twelve; rx pin open-drain.
 // RL9 - Mode 1: ten-bit frame, start, eight data LSB first, stop.
 // RL10 - Modes 1 and 2: buffer write starts sending; tx flag at stop bit start.
 // RL11 - Modes 1 and 2: receiver accepts characters any time while enabled.
 // RL12 - Mode 1: load data, stop bit to ninth bit, set flag if conditions hold.
 // RL13 - Mode 1 baud ticks are overflows of 8-bit or 16-bit auto-reload timers.
 // RL14 - Transmit and receive baud sources are selected independently.
 // RL15 - With a 16-bit timer, baud equals overflow rate over sixteen.
 // RL16 - Timer overflow rates: clock over 65536 minus reload, or 256 minus reload.
 // RL17 - Mode 2: eleven-bit frame with programmable ninth bit.
 // RL18 - Mode 2: ninth bit sent from tx_ninth_bit, received into rx_ninth_bit.
 // RL19 - Mode 2: load only if flag clear and filter off or addressed with ninth bit.
 // RL20 - Mode 2 baud is system clock over 64, or over 32 when doubled.
 // RL21 - Address match compares only bits set in the mask.
 // RL22 - Broadcast address is value OR mask, zeros being don't care.
 // RL23 - Mode 3 uses mode 2 framing and filtering with timer baud.
 // RL24 - Async receiver finds start edge, samples bit centres with sixteen ticks per bit.
*/
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH

`define ESP_A_CTRL    3'h0
`define ESP_A_DATA    3'h1
`define ESP_A_STAT    3'h2
`define ESP_A_AVAL    3'h3
`define ESP_A_AMSK    3'h4
`define ESP_A_T8RL    3'h5
`define ESP_A_T16L    3'h6
`define ESP_A_T16H    3'h7

`define ESP_C_RXDONE  0
`define ESP_C_TXDONE  1
`define ESP_C_RB8     2
`define ESP_C_TB8     3
`define ESP_C_REN     4
`define ESP_C_AFE     5
`define ESP_C_MODE    7:6

`define ESP_S_RXSEL   1:0
`define ESP_S_TXSEL   3:2
`define ESP_S_DBL     4
`define ESP_S_OVR     7

`define ESP_MODE0     2'h0
`define ESP_MODE1     2'h1
`define ESP_MODE2     2'h2
`define ESP_SEL_T8    2'h0

`define ESP_M0_LAST   4'hB
`define ESP_M0_HALF   4'h6
`define ESP_M0_BIT8   4'h7
`define ESP_OS_LAST   4'hF
`define ESP_OS_MID    4'h7
`define ESP_FIX_X1    4'h3
`define ESP_FIX_X2    4'h1
`define ESP_STOP_M1   4'h9
`define ESP_STOP_M23  4'hA
`define ESP_RXN_M1    4'h8
`define ESP_RXN_M23   4'h9

`endif

/* src/esp_pkg.sv */
/*
 Types shared by the serial port modules.
 Assumes esp_cfg.svh supplies the numeric constants.
*/
package esp_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_M0} esp_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_M0,
                              RX_M0_END} esp_rx_st_t;
endpackage

/* src/esp_timer.sv */
/*
 Free-running auto-reload up-counter that pulses on rollover.
 Assumes it counts every system clock; width chosen per instance.
*/
`timescale 1ns/1ps
`include "esp_cfg.svh"
module esp_timer
    import esp_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_reload,
    output logic              o_ovf
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         ovf_d;

    always_comb begin
        cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        ovf_d = 1'b0;
        if (&cnt_q) begin // RL13
            cnt_d = i_reload; // RL16
            ovf_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            o_ovf <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_ovf <= ovf_d;
        end
    end
endmodule

/* src/esp_pulse_div.sv */
/*
 Divides a pulse stream by (i_last + 1), one output pulse per wrap.
 Assumes i_clr restarts the count so a new frame gets a full period.
*/
`timescale 1ns/1ps
`include "esp_cfg.svh"
module esp_pulse_div
    import esp_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clr,
    input  wire logic       i_pulse,
    input  wire logic [3:0] i_last,
    output logic            o_tick
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (i_clr) begin
            cnt_d = 4'h0;
        end else if (i_pulse) begin
            if (cnt_q == i_last) begin
                cnt_d  = 4'h0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_q  <= 4'h0;
            o_tick <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            o_tick <= tick_d;
        end
    end
endmodule

/* src/esp_uart.sv */
/*
 Enhanced serial port: register file, baud sources, transmitter,
 receiver with holding register and address filter, mode 0 shifter.
 Assumes a single-cycle strobe register port and pins synchronous to
 i_core_clk; the rx pin wire is resolved outside from out/oe.
*/
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "esp_cfg.svh"
module esp_uart
    import esp_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    output logic      [7:0] o_rd_data,
    input  wire logic       i_serial_rx,
    output logic            o_serial_rx_out,
    output logic            o_serial_rx_oe,
    output logic            o_serial_tx,
    output logic            o_tx_done,
    output logic            o_rx_done
);
    // configuration
    logic [1:0]  mode_q;
    logic [1:0]  mode_d;
    logic        afe_q;
    logic        afe_d;
    logic        ren_q;
    logic        ren_d;
    logic        tb8_q;
    logic        tb8_d;
    logic        dbl_q;
    logic        dbl_d;
    logic [1:0]  txsel_q;
    logic [1:0]  txsel_d;
    logic [1:0]  rxsel_q;
    logic [1:0]  rxsel_d;
    logic [7:0]  aval_q;
    logic [7:0]  aval_d;
    logic [7:0]  amsk_q;
    logic [7:0]  amsk_d;
    logic [7:0]  t8rl_q;
    logic [7:0]  t8rl_d;
    logic [15:0] t16rl_q;
    logic [15:0] t16rl_d;
    // flags and receive buffer
    logic        txdone_q;
    logic        txdone_d;
    logic        rxdone_q;
    logic        rxdone_d;
    logic        rb8_q;
    logic        rb8_d;
    logic        ovr_q;
    logic        ovr_d;
    logic        unread_q;
    logic        unread_d;
    logic [7:0]  rxbuf_q;
    logic [7:0]  rxbuf_d;
    // transmitter
    esp_tx_st_t  tx_st_q;
    esp_tx_st_t  tx_st_d;
    logic [10:0] tx_sh_q;
    logic [10:0] tx_sh_d;
    logic [3:0]  tx_cnt_q;
    logic [3:0]  tx_cnt_d;
    logic        tx_set;
    // receiver
    esp_rx_st_t  rx_st_q;
    esp_rx_st_t  rx_st_d;
    logic [9:0]  rx_sh_q;
    logic [9:0]  rx_sh_d;
    logic [3:0]  rx_cnt_q;
    logic [3:0]  rx_cnt_d;
    logic [3:0]  rx_os_q;
    logic [3:0]  rx_os_d;
    logic        rx_prev_q;
    logic        rx_set;
    logic        rx_load;
    logic        rx_ld_rb8;
    logic        rx_rb8_val;
    logic [7:0]  rx_ld_data;
    logic [9:0]  rx_frame;
    // mode 0 phase and pins
    logic [3:0]  m0_ph_q;
    logic [3:0]  m0_ph_d;
    logic        tx_pin_d;
    logic        rx_oe_d;
    logic [7:0]  rd_d;

    logic        wr_ctrl;
    logic        wr_data;
    logic        wr_stat;
    logic        rd_data;
    logic        ovf8;
    logic        ovf16;
    logic        fix_tick;
    logic        tx_os;
    logic        rx_os;
    logic        tx_bit_tick;
    logic        tx_start;
    logic        m0_act;
    logic        m0_shift;
    logic        is_m1;
    logic [3:0]  tx_stop;
    logic [7:0]  bcast;
    logic        addr_ok;

    assign wr_ctrl  = i_wr_en && (i_addr == `ESP_A_CTRL);
    assign wr_data  = i_wr_en && (i_addr == `ESP_A_DATA);
    assign wr_stat  = i_wr_en && (i_addr == `ESP_A_STAT);
    assign rd_data  = i_rd_en && (i_addr == `ESP_A_DATA);
    assign is_m1    = (mode_q == `ESP_MODE1);
    assign tx_stop  = is_m1 ? `ESP_STOP_M1 : `ESP_STOP_M23;
    assign tx_start = wr_data && (tx_st_q == TX_IDLE); // RL3
    assign m0_act   = (tx_st_q == TX_M0) || (rx_st_q == RX_M0);
    assign m0_shift = m0_act && (m0_ph_q == `ESP_M0_LAST);

    // baud sources; an 8-bit source is also divided by sixteen per bit
    esp_timer #(.W(8)) u_tmr8 (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_reload   (t8rl_q),
        .o_ovf      (ovf8)
    );
    esp_timer #(.W(16)) u_tmr16 (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_reload   (t16rl_q),
        .o_ovf      (ovf16)
    );
    esp_pulse_div u_fixdiv (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clr      (1'b0),
        .i_pulse    (1'b1),
        .i_last     (dbl_q ? `ESP_FIX_X2 : `ESP_FIX_X1), // RL20
        .o_tick     (fix_tick)
    );
    always_comb begin
        if (mode_q == `ESP_MODE2) begin
            tx_os = fix_tick; // RL20
            rx_os = fix_tick;
        end else begin
            tx_os = (txsel_q == `ESP_SEL_T8) ? ovf8 : ovf16; // RL14
            rx_os = (rxsel_q == `ESP_SEL_T8) ? ovf8 : ovf16; // RL14
        end
    end
    esp_pulse_div u_txdiv (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clr      (tx_start),
        .i_pulse    (tx_os),
        .i_last     (`ESP_OS_LAST), // RL15
        .o_tick     (tx_bit_tick)
    );

    // configuration registers
    always_comb begin
        mode_d  = mode_q;
        afe_d   = afe_q;
        ren_d   = ren_q;
        tb8_d   = tb8_q;
        dbl_d   = dbl_q;
        txsel_d = txsel_q;
        rxsel_d = rxsel_q;
        aval_d  = aval_q;
        amsk_d  = amsk_q;
        t8rl_d  = t8rl_q;
        t16rl_d = t16rl_q;
        if (wr_ctrl) begin
            mode_d = i_wr_data[`ESP_C_MODE]; // RL1
            afe_d  = i_wr_data[`ESP_C_AFE];
            ren_d  = i_wr_data[`ESP_C_REN];
            tb8_d  = i_wr_data[`ESP_C_TB8];
        end
        if (wr_stat) begin
            dbl_d   = i_wr_data[`ESP_S_DBL];
            txsel_d = i_wr_data[`ESP_S_TXSEL];
            rxsel_d = i_wr_data[`ESP_S_RXSEL];
        end
        if (i_wr_en && (i_addr == `ESP_A_AVAL)) aval_d = i_wr_data;
        if (i_wr_en && (i_addr == `ESP_A_AMSK)) amsk_d = i_wr_data;
        if (i_wr_en && (i_addr == `ESP_A_T8RL)) t8rl_d = i_wr_data;
        if (i_wr_en && (i_addr == `ESP_A_T16L)) t16rl_d[7:0] = i_wr_data;
        if (i_wr_en && (i_addr == `ESP_A_T16H)) t16rl_d[15:8] = i_wr_data;
    end

    // transmitter, async and mode 0 share one shift register
    always_comb begin
        tx_st_d  = tx_st_q;
        tx_sh_d  = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        tx_set   = 1'b0;
        unique case (tx_st_q)
            TX_IDLE: begin
                if (tx_start) begin
                    tx_cnt_d = 4'h0;
                    if (mode_q == `ESP_MODE0) begin
                        tx_st_d = TX_M0; // RL5
                        tx_sh_d = {3'h7, i_wr_data};
                    end else begin
                        tx_st_d = TX_ASYNC; // RL10
                        // mode 1 sends its stop bit from the ninth-bit slot
                        tx_sh_d = {1'b1, (is_m1 | tb8_q), i_wr_data, 1'b0}; // RL9 RL17 RL18
                    end
                end
            end
            TX_ASYNC: begin
                if (tx_bit_tick) begin
                    tx_sh_d  = {1'b1, tx_sh_q[10:1]};
                    tx_cnt_d = tx_cnt_q + 4'h1;
                    if (tx_cnt_q == tx_stop) begin
                        tx_st_d = TX_IDLE;
                    end else if (tx_cnt_d == tx_stop) begin
                        tx_set = 1'b1; // RL10
                    end
                end
            end
            TX_M0: begin
                if (m0_shift) begin
                    tx_sh_d  = {1'b1, tx_sh_q[10:1]}; // RL6
                    tx_cnt_d = tx_cnt_q + 4'h1;
                    if (tx_cnt_q == `ESP_M0_BIT8) begin
                        tx_st_d = TX_IDLE;
                        tx_set  = 1'b1; // RL6
                    end
                end
            end
        endcase
    end

    // address filter
    assign bcast   = aval_q | amsk_q; // RL22
    assign rx_frame = {i_serial_rx, rx_sh_q[9:1]};
    always_comb begin
        addr_ok = (((rx_frame[7:0] ^ aval_q) & amsk_q) == 8'h00) || // RL21
                  (((rx_frame[7:0] ^ bcast) & bcast) == 8'h00); // RL22
    end

    // receiver
    always_comb begin
        rx_st_d    = rx_st_q;
        rx_sh_d    = rx_sh_q;
        rx_cnt_d   = rx_cnt_q;
        rx_os_d    = rx_os_q;
        rx_set     = 1'b0;
        rx_load    = 1'b0;
        rx_ld_rb8  = 1'b0;
        rx_rb8_val = 1'b0;
        rx_ld_data = 8'h00;
        unique case (rx_st_q)
            RX_IDLE: begin
                rx_cnt_d = 4'h0;
                rx_os_d  = 4'h0;
                if (mode_q == `ESP_MODE0) begin
                    // half duplex: a pending transmit goes first
                    if (ren_q && !rxdone_q && (tx_st_q == TX_IDLE) &&
                        !tx_start) begin
                        rx_st_d = RX_M0; // RL7
                    end
                end else if (ren_q && rx_prev_q && !i_serial_rx) begin
                    rx_st_d = RX_START; // RL11 RL24
                end
            end
            RX_START: begin
                if (rx_os) begin
                    if (rx_os_q == `ESP_OS_MID) begin
                        rx_os_d = 4'h0;
                        // a glitch shorter than half a bit is dropped
                        rx_st_d = i_serial_rx ? RX_IDLE : RX_BITS; // RL24
                    end else begin
                        rx_os_d = rx_os_q + 4'h1;
                    end
                end
            end
            RX_BITS: begin
                if (rx_os) begin
                    if (rx_os_q == `ESP_OS_LAST) begin
                        rx_os_d  = 4'h0;
                        rx_sh_d  = rx_frame; // RL24
                        rx_cnt_d = rx_cnt_q + 4'h1;
                        if (is_m1 && (rx_cnt_q == `ESP_RXN_M1)) begin
                            rx_st_d    = RX_IDLE;
                            rx_ld_data = rx_frame[8:1]; // RL12
                            rx_rb8_val = rx_frame[9];
                            rx_load    = !rxdone_q &&
                                         (!afe_q || rx_frame[9]); // RL12
                        end else if (!is_m1 &&
                                     (rx_cnt_q == `ESP_RXN_M23)) begin
                            rx_st_d    = RX_IDLE;
                            rx_ld_data = rx_frame[7:0]; // RL18 RL23
                            rx_rb8_val = rx_frame[8];
                            rx_load    = !rxdone_q && (!afe_q ||
                                         (rx_frame[8] && addr_ok)); // RL19 RL23
                        end
                        rx_ld_rb8 = rx_load;
                        rx_set    = rx_load;
                    end else begin
                        rx_os_d = rx_os_q + 4'h1;
                    end
                end
            end
            RX_M0: begin
                if (m0_shift) begin
                    rx_sh_d  = rx_frame; // RL5
                    rx_cnt_d = rx_cnt_q + 4'h1;
                    if (rx_cnt_q == `ESP_M0_BIT8) rx_st_d = RX_M0_END;
                end
            end
            RX_M0_END: begin
                rx_st_d    = RX_IDLE; // RL7
                rx_ld_data = rx_sh_q[9:2];
                rx_load    = 1'b1;
                rx_set     = 1'b1; // RL7
            end
            default: rx_st_d = RX_IDLE;
        endcase
    end

    // flags: hardware set wins over a software clear
    always_comb begin
        txdone_d = (wr_ctrl ? i_wr_data[`ESP_C_TXDONE] : txdone_q)
                   | tx_set; // RL2
        rxdone_d = (wr_ctrl ? i_wr_data[`ESP_C_RXDONE] : rxdone_q)
                   | rx_set; // RL2
        rb8_d    = wr_ctrl ? i_wr_data[`ESP_C_RB8] : rb8_q;
        if (rx_ld_rb8) rb8_d = rx_rb8_val; // RL12 RL18
        rxbuf_d  = rx_load ? rx_ld_data : rxbuf_q; // RL4
        unread_d = rx_load | (unread_q & !rd_data);
        ovr_d    = (wr_stat ? i_wr_data[`ESP_S_OVR] : ovr_q)
                   | (rx_load & unread_q & !rd_data); // RL4
    end

    // mode 0 phase and registered pin drive
    always_comb begin
        m0_ph_d = 4'h0;
        if (m0_act && (m0_ph_q != `ESP_M0_LAST)) begin
            m0_ph_d = m0_ph_q + 4'h1; // RL8
        end
        tx_pin_d = 1'b1;
        rx_oe_d  = 1'b0;
        if (tx_st_d == TX_ASYNC) begin
            tx_pin_d = tx_sh_d[0];
        end else if ((tx_st_d == TX_M0) || (rx_st_d == RX_M0)) begin
            tx_pin_d = (m0_ph_d >= `ESP_M0_HALF); // RL5 RL8
            rx_oe_d  = (tx_st_d == TX_M0) && !tx_sh_d[0]; // RL8
        end
    end

    always_comb begin
        rd_d = 8'h00;
        if (i_rd_en) begin
            unique case (i_addr)
                `ESP_A_CTRL: rd_d = {mode_q, afe_q, ren_q, tb8_q, rb8_q,
                                     txdone_q, rxdone_q};
                `ESP_A_DATA: rd_d = rxbuf_q; // RL3
                `ESP_A_STAT: rd_d = {ovr_q, 2'h0, dbl_q, txsel_q, rxsel_q};
                `ESP_A_AVAL: rd_d = aval_q;
                `ESP_A_AMSK: rd_d = amsk_q;
                `ESP_A_T8RL: rd_d = t8rl_q;
                `ESP_A_T16L: rd_d = t16rl_q[7:0];
                `ESP_A_T16H: rd_d = t16rl_q[15:8];
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_q          <= `ESP_MODE0;
            afe_q           <= 1'b0;
            ren_q           <= 1'b0;
            tb8_q           <= 1'b0;
            dbl_q           <= 1'b0;
            txsel_q         <= `ESP_SEL_T8;
            rxsel_q         <= `ESP_SEL_T8;
            aval_q          <= 8'h00;
            amsk_q          <= 8'h00;
            t8rl_q          <= 8'h00;
            t16rl_q         <= 16'h0000;
            txdone_q        <= 1'b0;
            rxdone_q        <= 1'b0;
            rb8_q           <= 1'b0;
            ovr_q           <= 1'b0;
            unread_q        <= 1'b0;
            rxbuf_q         <= 8'h00;
            tx_st_q         <= TX_IDLE;
            tx_sh_q         <= 11'h7FF;
            tx_cnt_q        <= 4'h0;
            rx_st_q         <= RX_IDLE;
            rx_sh_q         <= 10'h000;
            rx_cnt_q        <= 4'h0;
            rx_os_q         <= 4'h0;
            rx_prev_q       <= 1'b1;
            m0_ph_q         <= 4'h0;
            o_serial_tx     <= 1'b1;
            o_serial_rx_oe  <= 1'b0;
            o_rd_data       <= 8'h00;
        end else begin
            mode_q          <= mode_d;
            afe_q           <= afe_d;
            ren_q           <= ren_d;
            tb8_q           <= tb8_d;
            dbl_q           <= dbl_d;
            txsel_q         <= txsel_d;
            rxsel_q         <= rxsel_d;
            aval_q          <= aval_d;
            amsk_q          <= amsk_d;
            t8rl_q          <= t8rl_d;
            t16rl_q         <= t16rl_d;
            txdone_q        <= txdone_d;
            rxdone_q        <= rxdone_d;
            rb8_q           <= rb8_d;
            ovr_q           <= ovr_d;
            unread_q        <= unread_d;
            rxbuf_q         <= rxbuf_d;
            tx_st_q         <= tx_st_d;
            tx_sh_q         <= tx_sh_d;
            tx_cnt_q        <= tx_cnt_d;
            rx_st_q         <= rx_st_d;
            rx_sh_q         <= rx_sh_d;
            rx_cnt_q        <= rx_cnt_d;
            rx_os_q         <= rx_os_d;
            rx_prev_q       <= i_serial_rx;
            m0_ph_q         <= m0_ph_d;
            o_serial_tx     <= tx_pin_d;
            o_serial_rx_oe  <= rx_oe_d;
            o_rd_data       <= rd_d;
        end
    end

    // open drain: only ever pulls low
    assign o_serial_rx_out = 1'b0;
    assign o_tx_done       = txdone_q;
    assign o_rx_done       = rxdone_q;
endmodule

/* tb/esp_asserts.sv */
/*
 Port checker for esp_uart.
 Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module esp_asserts (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic [2:0] i_addr,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_serial_rx_out,
    input wire logic       o_serial_rx_oe,
    input wire logic       o_serial_tx,
    input wire logic       o_tx_done,
    input wire logic       o_rx_done
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // only a control write may lower a flag
    wire ctl_wr = i_wr_en && (i_addr == 3'h0);

    chk_od_low: assert property (o_serial_rx_out == 1'b0)
        else $error("rx pin drive value not low");
    chk_rd_idle: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
        else $error("read data outside read slot");
    chk_tx_flag_keep: assert property (o_tx_done && !ctl_wr |=> o_tx_done)
        else $error("tx flag cleared by hardware");
    chk_rx_flag_keep: assert property (o_rx_done && !ctl_wr |=> o_rx_done)
        else $error("rx flag cleared by hardware");
    chk_clk_low: assert property ($fell(o_serial_tx) |-> !o_serial_tx [*6])
        else $error("tx line low too short");
    chk_clk_high: assert property ($rose(o_serial_tx) |-> o_serial_tx [*6])
        else $error("tx line high too short");
    chk_done_stop: assert property ($rose(o_tx_done) && !$past(ctl_wr)
        |-> ##[0:2] o_serial_tx)
        else $error("tx flag not at stop or idle");
    chk_oe_clk_low: assert property ($rose(o_serial_rx_oe) |-> !o_serial_tx)
        else $error("data driven outside clock low");
    cover property ($rose(o_tx_done));
    cover property ($rose(o_rx_done));
    cover property ($rose(o_serial_rx_oe));
endmodule

/* tb/esp_remote.sv */
/*
 Remote serial device on the rx wire.
 Assumes send is called just after a clock edge.
*/
`timescale 1ns/1ps
module esp_remote (
    input  wire logic i_core_clk,
    input  wire logic i_oe,
    output logic      o_line
);
    logic drv_q = 1'b1;
    assign o_line = i_oe ? 1'b0 : drv_q;
    // frame bits go out LSB first, per clocks each
    task send(input logic [10:0] b, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            drv_q <= b[i];
            repeat (per) @(posedge i_core_clk);
        end
    endtask
endmodule

/* tb/esp_uart_tb_top.sv */
/*
 Bench: mode 0 and async transmit, filtered receive, overrun.
 Assumes esp_remote pulls the rx wire up.
*/
`timescale 1ns/1ps
module esp_uart_tb_top;
    logic       i_core_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wr_data = 8'h00;
    logic       i_wr_en = 1'b0;
    logic       i_rd_en = 1'b0;
    logic [7:0] o_rd_data;
    logic       rx_line, rx_oe, o_serial_tx, o_tx_done, o_rx_done;
    int         mismatches = 0;
    int         samples_checked = 0;
    always #10 i_core_clk = ~i_core_clk;
    esp_uart dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_serial_rx(rx_line),
        .o_serial_rx_out(), .o_serial_rx_oe(rx_oe),
        .o_serial_tx(o_serial_tx), .o_tx_done(o_tx_done),
        .o_rx_done(o_rx_done));
    esp_remote remote (.i_core_clk(i_core_clk), .i_oe(rx_oe),
        .o_line(rx_line));

    task results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cmpb(input logic g, input logic e);
        cmp({7'h00, g}, {7'h00, e});
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_core_clk);
        i_rd_en <= 1'b0;
        #1 cmp(o_rd_data, e);
    endtask
    task wait_tx;
        for (int n = 0; o_serial_tx !== 1'b0; n++) begin
            tick(1);
            if (n > 300) begin
                mismatches++;
                results();
            end
        end
    endtask
    task t_m0_tx(input logic [7:0] d);
        logic [7:0] got;
        wr(1, d);
        wait_tx();
        for (int i = 0; i < 8; i++) begin
            tick(6);
            got[i] = rx_line;
            tick(6);
        end
        cmp(got, d);
        tick(1);
        cmpb(o_tx_done, 1'b1);
        wr(0, 8'h00);
        $display("mode 0 tx done");
    endtask
    task t_tx(input logic [7:0] c, s, d, input int per, n);
        logic [10:0] f;
        f = {1'b1, c[3], d, 1'b0};
        f[9] = (n == 10) | c[3];
        wr(2, s);
        wr(0, c);
        wr(1, d);
        wait_tx();
        tick(per / 2);
        for (int i = 0; i < n - 1; i++) begin
            cmpb(o_serial_tx, f[i]);
            if (i == n - 2) cmpb(o_tx_done, 1'b0);
            tick(per);
        end
        cmpb(o_serial_tx, 1'b1);
        cmpb(o_tx_done, 1'b1);
        tick(per);
        wr(0, c);
        $display("async tx done");
    endtask
    task t_rx(input logic [7:0] d, input logic b9, ok, input logic [7:0] c);
        remote.send({1'b1, b9, d, 1'b0}, 11, 32);
        tick(8);
        cmpb(o_rx_done, ok);
        if (ok) begin
            rd(0, c | {5'h00, b9, 2'h1});
            rd(1, d);
            wr(0, c);
        end
        $display("rx done");
    endtask

    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(0, 8'h00);
        t_m0_tx(8'hA5);
        wr(0, 8'h10);
        tick(110);
        rd(0, 8'h11);
        rd(1, 8'hFF);
        wr(5, 8'hFE);
        wr(6, 8'hFE);
        wr(7, 8'hFF);
        // wide timer rolls over first from zero
        tick(65535);
        t_tx(8'h88, 8'h00, 8'h3C, 64, 11);
        t_tx(8'h80, 8'h10, 8'hC3, 32, 11);
        t_tx(8'h40, 8'h00, 8'h5A, 32, 10);
        t_tx(8'hC8, 8'h04, 8'h96, 32, 11);
        wr(2, 8'h01);
        wr(3, 8'h35);
        wr(4, 8'h0F);
        wr(0, 8'hF0);
        t_rx(8'hF5, 1'b1, 1'b1, 8'hF0);
        t_rx(8'h36, 1'b1, 1'b0, 8'hF0);
        t_rx(8'hFF, 1'b1, 1'b1, 8'hF0);
        t_rx(8'h35, 1'b0, 1'b0, 8'hF0);
        wr(0, 8'h50);
        t_rx(8'hA7, 1'b1, 1'b1, 8'h50);
        wr(0, 8'hD0);
        remote.send({2'b11, 8'h11, 1'b0}, 11, 32);
        remote.send({2'b10, 8'h33, 1'b0}, 11, 32);
        tick(8);
        rd(0, 8'hD5);
        wr(0, 8'hD0);
        t_rx(8'h22, 1'b1, 1'b1, 8'hD0);
        rd(2, 8'h81);
        results();
    end
endmodule

bind esp_uart esp_asserts u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .o_serial_rx_out(o_serial_rx_out),
    .o_serial_rx_oe(o_serial_rx_oe), .o_serial_tx(o_serial_tx),
    .o_tx_done(o_tx_done), .o_rx_done(o_rx_done));
